// ### core/sfc_defines.vh
/*
 * Constants for the synthesizer and reference clock control block.
 * Assumes a 250 MHz system clock and a 32-bit Avalon-MM register bus.
 */
`ifndef SFC_DEFINES_VH
`define SFC_DEFINES_VH
// ----------------------------------------------------------------------------
// Register addresses, one bus index per byte register
// ----------------------------------------------------------------------------
`define SFC_IDX_FREQ_HI      8'h07
`define SFC_IDX_FREQ_MID     8'h08
`define SFC_IDX_FREQ_LO      8'h09
`define SFC_IDX_REF_SEL      8'h59
`define SFC_IDX_CTRL         8'h60
`define SFC_IDX_PIN_MAP      8'h61
`define SFC_IDX_PIN_MAP_TWO  8'h62
`define SFC_IDX_BAT_THRESH   8'h63
`define SFC_IDX_STATUS       8'h64
`define SFC_IDX_IRQ_STAT     8'h65
`define SFC_IDX_IRQ_MASK     8'h66
`define SFC_IDX_FREQ_ACTIVE  8'h67
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SFC_REF_EXT_BIT      4
`define SFC_CTRL_SEQ_BIT     0
`define SFC_CTRL_OSC_BIT     1
`define SFC_CTRL_PLL_BIT     2
`define SFC_CTRL_RX_BIT      3
`define SFC_CTRL_SLEEP_BIT   4
`define SFC_IRQ_LOWBAT_BIT   0
`define SFC_IRQ_LOCK_BIT     1
`define SFC_IRQ_RXON_BIT     2
// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SFC_RST_FREQ         24'he4_c000
`define SFC_RST_FREQ_HI      8'he4
`define SFC_RST_FREQ_MID     8'hc0
`define SFC_RST_FREQ_LO      8'h00
`define SFC_RST_CTRL         8'h01
`define SFC_RST_PIN_MAP      8'h00
`define SFC_RST_PIN_MAP_TWO  8'h00
`define SFC_RST_BAT_THRESH   8'h02
`define SFC_RST_MASK         8'h00
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SFC_CLK_MHZ          250
`define SFC_CAL_COARSE_NS    2000
`define SFC_CAL_FINE_NS      400
// Calibration lengths in clock cycles, sized to the calibration counter.
`define SFC_CAL_COARSE_CYC   10'h1f4
`define SFC_CAL_FINE_CYC     10'h064
`endif

// ### core/sfc_top.v
/*
 * Synthesizer and reference clock control: start-up sequencing, carrier
 * word staging, lock indication, VCO calibration, clock output and the
 * low battery interrupt, with an Avalon-MM register slave.
 * Assumes osc_stable, pll_locked and supply_level come from the analog side
 * asynchronously; they pass a three-stage synchroniser.
 */
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ns
`include "sfc_defines.vh"
`default_nettype none

// Summary of operation
// - A supply level under the battery threshold sets a sticky interrupt; its flag is routable to pins 0 to 4, or pin 5 with the clock off.
// - With the sequencer on, the PLL starts as soon as the oscillator is stable.
// - The reference clock output stays quiet until the oscillator is stable.
// - Bit 4 of the source select register chooses the external reference over the crystal.
// - General pin five carries the reference halved or divided further, as chosen by the second map.
// - The clock output is enabled at reset and stopped in Sleep or by select 7 of the second map.
// - Coarse calibration runs once after reset and fine calibration at each PLL start.
// - One frequency step is the reference divided by two to the nineteenth.
// - The carrier is step times a 24-bit word held in three byte registers.
// - A new carrier word takes effect only when its low byte is written.
// - With the sequencer on, the receiver starts once the PLL reports lock.
// - The lock indicator rises in locking range and is mappable to general pins.
module sfc_top (
   input  wire        clk_sys,
   input  wire        rst,
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   input  wire        osc_stable,
   input  wire        pll_locked,
   input  wire [7:0]  supply_level,
   output reg         osc_enable_q,
   output reg         ext_ref_sel_q,
   output reg         pll_enable_q,
   output reg         rx_enable_q,
   output reg         vco_cal_q,
   output reg         vco_cal_fine_q,
   output reg  [23:0] carrier_word_q,
   output reg  [5:0]  general_pin_q,
   output reg         irq_q
);
   // -------------------------------------------------------------------------
   // Registers and state
   // -------------------------------------------------------------------------
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_CAL  = 4'b0010;
   localparam [3:0] ST_LOCK = 4'b0100;
   localparam [3:0] ST_RX   = 4'b1000;

   reg  [7:0]  freq_hi_q;
   reg  [7:0]  freq_mid_q;
   reg  [7:0]  freq_lo_q;
   reg  [7:0]  ref_sel_q;
   reg  [7:0]  ctrl_q;
   reg  [7:0]  pin_map_q;
   reg  [7:0]  pin_map_two_q;
   reg  [7:0]  bat_thresh_q;
   reg  [7:0]  irq_stat_q;
   reg  [7:0]  irq_mask_q;
   reg  [3:0]  state_q;
   reg  [9:0]  cal_cnt_q;
   reg         coarse_done_q;
   reg         lock_ind_q;
   reg         relock_q;
   reg         clk_on_q;
   reg  [6:0]  div_cnt_q;
   reg         div_clk_q;
   reg  [2:0]  osc_sync_q;
   reg  [2:0]  lock_sync_q;
   reg  [7:0]  sup_s1_q;
   reg  [7:0]  sup_s2_q;
   reg  [7:0]  sup_s3_q;
   reg         osc_ok_q;
   reg         lock_ok_q;
   reg         lowbat_q;
   reg         bus_done_q;

   wire        sel_seq   = ctrl_q[`SFC_CTRL_SEQ_BIT];
   wire        sleep     = ctrl_q[`SFC_CTRL_SLEEP_BIT];
   wire        bus_req   = (avs_read | avs_write) & ~bus_done_q;
   wire        wr_take   = avs_write & ~bus_done_q;
   wire        rd_take   = avs_read & ~bus_done_q;
   wire        lo_write  = wr_take & (avs_address == `SFC_IDX_FREQ_LO);
   wire        pll_start = (state_q == ST_IDLE) & pll_enable_q & osc_ok_q & coarse_done_q;
   wire [7:0]  irq_events;
   wire        lowbat_now;

   // -------------------------------------------------------------------------
   // Synchronisers: a change counts once stages two and three agree.
   // -------------------------------------------------------------------------
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         osc_sync_q  <= 3'h0;
         lock_sync_q <= 3'h0;
         sup_s1_q    <= 8'hff;
         sup_s2_q    <= 8'hff;
         sup_s3_q    <= 8'hff;
         osc_ok_q    <= 1'b0;
         lock_ok_q   <= 1'b0;
      end else begin
         osc_sync_q  <= {osc_sync_q[1:0], osc_stable};
         lock_sync_q <= {lock_sync_q[1:0], pll_locked};
         sup_s1_q    <= supply_level;
         sup_s2_q    <= sup_s1_q;
         sup_s3_q    <= sup_s2_q;
         if (osc_sync_q[1] == osc_sync_q[2]) osc_ok_q <= osc_sync_q[2];
         if (lock_sync_q[1] == lock_sync_q[2]) lock_ok_q <= lock_sync_q[2];
      end
   end

   // Supply compare uses settled samples only, so a bus skew cannot glitch it.
   assign lowbat_now = (sup_s2_q == sup_s3_q) & (sup_s3_q < bat_thresh_q);
   // Event bits: low battery rise, lock while receiving, lock while waiting.
   assign irq_events = {5'h00, (state_q == ST_LOCK) & (lock_ok_q & ~relock_q),
                        lock_ok_q & ~lock_ind_q & (state_q == ST_RX), lowbat_now & ~lowbat_q};

   // -------------------------------------------------------------------------
   // Avalon slave: one wait cycle, then the answer; unmapped reads give zero.
   // -------------------------------------------------------------------------
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         // Staging bytes start as the bytes of the applied word, so a
         // read-back after reset agrees with the active word register.
         freq_hi_q     <= `SFC_RST_FREQ_HI;
         freq_mid_q    <= `SFC_RST_FREQ_MID;
         freq_lo_q     <= `SFC_RST_FREQ_LO;
         ref_sel_q     <= 8'h00;
         ctrl_q        <= `SFC_RST_CTRL;
         pin_map_q     <= `SFC_RST_PIN_MAP;
         pin_map_two_q <= `SFC_RST_PIN_MAP_TWO;
         bat_thresh_q  <= `SFC_RST_BAT_THRESH;
         irq_mask_q    <= `SFC_RST_MASK;
         irq_stat_q    <= 8'h00;
         avs_readdata  <= 32'h0000_0000;
         bus_done_q    <= 1'b0;
         lowbat_q      <= 1'b0;
      end else begin
         bus_done_q <= bus_req;
         lowbat_q   <= lowbat_now;
         // Write-one-to-clear; a new event in the same cycle wins.
         irq_stat_q <= (irq_stat_q & ~((wr_take && avs_address == `SFC_IDX_IRQ_STAT) ?
                        avs_writedata[7:0] : 8'h00)) | irq_events;
         if (wr_take) begin
            case (avs_address)
               `SFC_IDX_FREQ_HI:     freq_hi_q     <= avs_writedata[7:0];
               `SFC_IDX_FREQ_MID:    freq_mid_q    <= avs_writedata[7:0];
               `SFC_IDX_FREQ_LO:     freq_lo_q     <= avs_writedata[7:0];
               `SFC_IDX_REF_SEL:     ref_sel_q     <= avs_writedata[7:0];
               `SFC_IDX_CTRL:        ctrl_q        <= avs_writedata[7:0];
               `SFC_IDX_PIN_MAP:     pin_map_q     <= avs_writedata[7:0];
               `SFC_IDX_PIN_MAP_TWO: pin_map_two_q <= avs_writedata[7:0];
               `SFC_IDX_BAT_THRESH:  bat_thresh_q  <= avs_writedata[7:0];
               `SFC_IDX_IRQ_MASK:    irq_mask_q    <= avs_writedata[7:0];
               default: ;
            endcase
         end
         if (rd_take) begin
            case (avs_address)
               `SFC_IDX_FREQ_HI:     avs_readdata <= {24'h00_0000, freq_hi_q};
               `SFC_IDX_FREQ_MID:    avs_readdata <= {24'h00_0000, freq_mid_q};
               `SFC_IDX_FREQ_LO:     avs_readdata <= {24'h00_0000, freq_lo_q};
               `SFC_IDX_REF_SEL:     avs_readdata <= {24'h00_0000, ref_sel_q};
               `SFC_IDX_CTRL:        avs_readdata <= {24'h00_0000, ctrl_q};
               `SFC_IDX_PIN_MAP:     avs_readdata <= {24'h00_0000, pin_map_q};
               `SFC_IDX_PIN_MAP_TWO: avs_readdata <= {24'h00_0000, pin_map_two_q};
               `SFC_IDX_BAT_THRESH:  avs_readdata <= {24'h00_0000, bat_thresh_q};
               `SFC_IDX_STATUS:      avs_readdata <= {24'h00_0000, lowbat_q, clk_on_q, coarse_done_q,
                                                      lock_ind_q, osc_ok_q, state_q[1], state_q[2], state_q[3]};
               `SFC_IDX_IRQ_STAT:    avs_readdata <= {24'h00_0000, irq_stat_q};
               `SFC_IDX_IRQ_MASK:    avs_readdata <= {24'h00_0000, irq_mask_q};
               `SFC_IDX_FREQ_ACTIVE: avs_readdata <= {8'h00, carrier_word_q};
               default:              avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Waitrequest drops for exactly the cycle after a request is seen.
   // A request still held at its answer is not taken twice: bus_done_q masks it.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~bus_req;
      end
   end

   // -------------------------------------------------------------------------
   // Start-up sequencer and VCO calibration.
   // -------------------------------------------------------------------------
   // In manual mode the PLL bit drives its enable directly, the oscillator follows Sleep only
   // and the receiver bit still waits for lock; the sequencer chains the PLL on stable reports.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q        <= ST_IDLE;
         osc_enable_q   <= 1'b1;
         ext_ref_sel_q  <= 1'b0;
         pll_enable_q   <= 1'b0;
         rx_enable_q    <= 1'b0;
         vco_cal_q      <= 1'b0;
         vco_cal_fine_q <= 1'b0;
         cal_cnt_q      <= 10'h000;
         coarse_done_q  <= 1'b0;
         carrier_word_q <= `SFC_RST_FREQ;
         lock_ind_q     <= 1'b0;
         relock_q       <= 1'b0;
      end else begin
         ext_ref_sel_q <= ref_sel_q[`SFC_REF_EXT_BIT];
         osc_enable_q  <= ~sleep;
         pll_enable_q  <= ~sleep & (sel_seq ? osc_ok_q : ctrl_q[`SFC_CTRL_PLL_BIT]);
         // Coarse calibration runs once, as soon as the oscillator settles.
         // The PLL may already be enabled; its fine calibration waits for this.
         if (!coarse_done_q && osc_ok_q && !vco_cal_q) begin
            vco_cal_q      <= 1'b1;
            vco_cal_fine_q <= 1'b0;
            cal_cnt_q      <= `SFC_CAL_COARSE_CYC;
         end else if (vco_cal_q) begin
            if (cal_cnt_q == 10'h001) begin
               vco_cal_q <= 1'b0;
               if (!vco_cal_fine_q) coarse_done_q <= 1'b1;
            end
            cal_cnt_q <= cal_cnt_q - 10'h001;
         end
         // Word applies on the low byte; upper bytes wait in staging.
         if (lo_write) begin
            carrier_word_q <= {freq_hi_q, freq_mid_q, avs_writedata[7:0]};
            relock_q       <= 1'b1;
            lock_ind_q     <= 1'b0;
         end else begin
            if (!lock_ok_q) relock_q <= 1'b0;
            lock_ind_q <= lock_ok_q & ~relock_q & pll_enable_q & ~vco_cal_q;
         end
         case (state_q)
            ST_IDLE: begin
               rx_enable_q <= 1'b0;
               if (pll_start) begin
                  state_q        <= ST_CAL;
                  vco_cal_q      <= 1'b1;
                  vco_cal_fine_q <= 1'b1;
                  cal_cnt_q      <= `SFC_CAL_FINE_CYC;
               end
            end
            ST_CAL: begin
               if (!pll_enable_q) state_q <= ST_IDLE;
               else if (!vco_cal_q) state_q <= ST_LOCK;
            end
            ST_LOCK: begin
               if (!pll_enable_q) state_q <= ST_IDLE;
               else if (lock_ind_q && (sel_seq || ctrl_q[`SFC_CTRL_RX_BIT])) begin
                  state_q     <= ST_RX;
                  rx_enable_q <= 1'b1;
               end
            end
            ST_RX: begin
               if (!pll_enable_q) state_q <= ST_IDLE;
               rx_enable_q <= pll_enable_q & (sel_seq | ctrl_q[`SFC_CTRL_RX_BIT]);
               if (!sel_seq && !ctrl_q[`SFC_CTRL_RX_BIT]) state_q <= ST_LOCK;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Clock output divider and pin mapping.
   // -------------------------------------------------------------------------
   // Selects 0 and 1 both halve the reference, a select n from 2 to 6
   // divides it by 2^n, and 7 turns the output off. The divider runs free,
   // so a new select needs no restart, but the first period after a change
   // may be short.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         div_cnt_q     <= 7'h00;
         div_clk_q     <= 1'b0;
         clk_on_q      <= 1'b1;
         general_pin_q <= 6'h00;
         irq_q         <= 1'b0;
      end else begin
         // Enabled from reset, yet the pin only follows once the oscillator is stable.
         clk_on_q  <= osc_ok_q & ~sleep & (pin_map_two_q[2:0] != 3'h7);
         div_cnt_q <= div_cnt_q + 7'h01;
         div_clk_q <= (pin_map_two_q[2:0] == 3'h0) ? ~div_clk_q : div_cnt_q[pin_map_two_q[2:0] - 3'h1];
         irq_q     <= |(irq_stat_q & irq_mask_q);
         // Pins 0 to 3 show lock or low battery, pin 4 the receiver enable or low battery.
         general_pin_q[0] <= pin_map_q[0] ? lowbat_q : lock_ind_q;
         general_pin_q[1] <= pin_map_q[1] ? lowbat_q : lock_ind_q;
         general_pin_q[2] <= pin_map_q[2] ? lowbat_q : lock_ind_q;
         general_pin_q[3] <= pin_map_q[3] ? lowbat_q : lock_ind_q;
         general_pin_q[4] <= pin_map_q[4] ? lowbat_q : rx_enable_q;
         general_pin_q[5] <= clk_on_q ? div_clk_q : (pin_map_q[5] & lowbat_q);
      end
   end
   // Carrier = (reference / 2^19) * carrier_word_q; step is fixed by the
   // modulator width, so only the word is held here.
endmodule
`default_nettype wire

// ### testbench/sfc_analog_model.sv
/* Behavioural oscillator and PLL on the far side of sfc_top.
   Assumes enables and the applied carrier word come from sfc_top. */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Analog model
// ----------------------------------------
module sfc_analog_model #(
   parameter int OSC_DLY = 40,
   parameter int PLL_DLY = 30
) (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        osc_enable,
   input wire logic        pll_enable,
   input wire logic [23:0] carrier_word,
   output logic            osc_stable,
   output logic            pll_locked
);
   int         osc_cnt;
   int         pll_cnt;
   logic [23:0] word_q;
   // Lock is lost on any word change, so a relock is really exercised.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         osc_cnt <= 0;
         pll_cnt <= 0;
         word_q <= 24'h00_0000;
      end else begin
         word_q <= carrier_word;
         osc_cnt <= !osc_enable ? 0 : (osc_cnt < OSC_DLY) ? osc_cnt + 1 : osc_cnt;
         pll_cnt <= (!pll_enable || carrier_word != word_q) ? 0 : (pll_cnt < PLL_DLY) ? pll_cnt + 1 : pll_cnt;
      end
   end
   assign osc_stable = (osc_cnt == OSC_DLY);
   assign pll_locked = (pll_cnt == PLL_DLY) && osc_stable;
endmodule
`default_nettype wire

// ### testbench/sfc_top_monitor.sv
/* Port checker for sfc_top.
   Assumes it is bound to sfc_top and sees only its ports. */
`timescale 1ns/1ns
`include "sfc_defines.vh"
`default_nettype none
// ----------------------------------------
// Checker
// ----------------------------------------
module sfc_top_monitor (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic        avs_waitrequest,
   input wire logic        osc_stable,
   input wire logic        pll_locked,
   input wire logic        ext_ref_sel_q,
   input wire logic        pll_enable_q,
   input wire logic        rx_enable_q,
   input wire logic        vco_cal_q,
   input wire logic        vco_cal_fine_q,
   input wire logic [23:0] carrier_word_q,
   input wire logic [5:0]  general_pin_q
);
   logic [3:0] quiet_q;
   wire        lo_take;
   wire        ref_take;
   // Cycles since the oscillator was stable; saturates, since the synchroniser lag is short.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) quiet_q <= 4'h0;
      else if (osc_stable) quiet_q <= 4'h0;
      else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
   end
   // Write requests on the edge where they are taken.
   assign lo_take = avs_write && avs_waitrequest && (avs_address == `SFC_IDX_FREQ_LO);
   assign ref_take = avs_write && avs_waitrequest && (avs_address == `SFC_IDX_REF_SEL);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("answer not one cycle after request");
   a_wait_low_once: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   // The select register is taken on the first edge and copied out on the next.
   a_ext_ref_bit: assert property (ref_take |-> ##2 (ext_ref_sel_q == $past(avs_writedata[4], 2)))
      else $error("reference source not taken from bit 4");
   a_carrier_apply: assert property (lo_take |=> carrier_word_q[7:0] == $past(avs_writedata[7:0]))
      else $error("low byte not applied");
   a_carrier_hold: assert property (!lo_take |=> $stable(carrier_word_q))
      else $error("carrier word changed without low byte write");
   a_pll_after_osc: assert property ($rose(pll_enable_q) |-> osc_stable && $past(osc_stable, 2))
      else $error("pll started before oscillator stable");
   // The first start waits for the coarse run of 500 cycles before the fine one.
   a_fine_cal_start: assert property ($rose(pll_enable_q) |-> ##[0:600] (vco_cal_q && vco_cal_fine_q))
      else $error("no fine calibration at pll start");
   a_rx_after_lock: assert property ($rose(rx_enable_q) |-> pll_locked && $past(pll_locked, 2))
      else $error("receiver started before lock");
   a_clk_out_quiet: assert property ($changed(general_pin_q[5]) |-> quiet_q < 4'h8)
      else $error("clock output moved without stable oscillator");
   a_lock_ind_drop: assert property (lo_take |-> ##[1:3] !general_pin_q[0])
      else $error("lock indicator kept after new carrier word");
endmodule
bind sfc_top sfc_top_monitor u_mon (
   .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
   .osc_stable(osc_stable), .pll_locked(pll_locked), .ext_ref_sel_q(ext_ref_sel_q),
   .pll_enable_q(pll_enable_q), .rx_enable_q(rx_enable_q), .vco_cal_q(vco_cal_q),
   .vco_cal_fine_q(vco_cal_fine_q), .carrier_word_q(carrier_word_q), .general_pin_q(general_pin_q));
`default_nettype wire

// ### testbench/tb_synth_freq_control.sv
/* Self-checking bench for sfc_top with an analog model.
   Assumes core/ is on the include path. */
`timescale 1ns/1ns
`include "sfc_defines.vh"
`default_nettype none
module tb_synth_freq_control;
   logic        clk_sys = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [7:0]  avs_address = 8'h00, supply_level = 8'h80;
   logic [31:0] avs_writedata = 32'h0000_0000, seed = 32'h0000_cca3;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest, osc_stable, pll_locked, osc_enable_q, ext_ref_sel_q;
   wire         pll_enable_q, rx_enable_q, vco_cal_q, vco_cal_fine_q, irq_q;
   wire  [23:0] carrier_word_q;
   wire  [5:0]  general_pin_q;
   logic [31:0] exp_q[$];
   logic        saw_coarse = 1'b0, saw_fine = 1'b0;
   int          mismatches = 0, checks = 0, cyc = 0, i, n, k;
   logic [7:0]  sel [4] = '{8'h00, 8'h01, 8'h02, 8'h07};
   always #2 clk_sys = ~clk_sys;
   sfc_top dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .osc_stable(osc_stable), .pll_locked(pll_locked),
      .supply_level(supply_level), .osc_enable_q(osc_enable_q), .ext_ref_sel_q(ext_ref_sel_q),
      .pll_enable_q(pll_enable_q), .rx_enable_q(rx_enable_q), .vco_cal_q(vco_cal_q),
      .vco_cal_fine_q(vco_cal_fine_q), .carrier_word_q(carrier_word_q),
      .general_pin_q(general_pin_q), .irq_q(irq_q));
   sfc_analog_model u_ana (.clk_sys(clk_sys), .rst(rst), .osc_enable(osc_enable_q),
      .pll_enable(pll_enable_q), .carrier_word(carrier_word_q), .osc_stable(osc_stable),
      .pll_locked(pll_locked));
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // One Avalon cycle: hold everything until waitrequest is sampled low.
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h00_0000, d};
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic rd8(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back({24'h00_0000, e});
      bus(1'b0, a, 8'h00);
   endtask
   task automatic toggles(output int t);
      logic last;
      t = 0;
      last = general_pin_q[5];
      repeat (64) begin
         @(posedge clk_sys);
         if (general_pin_q[5] !== last) t++;
         last = general_pin_q[5];
      end
   endtask
   // Read results are compared against the oldest note when the answer stands.
   always @(posedge clk_sys) begin
      if (avs_read && avs_waitrequest === 1'b0) check_val(avs_readdata, exp_q.pop_front());
      if (vco_cal_q === 1'b1) begin
         saw_coarse <= saw_coarse | (vco_cal_fine_q === 1'b0);
         saw_fine <= saw_fine | (vco_cal_fine_q === 1'b1);
      end
      cyc++;
      if (cyc == 30000) begin
         mismatches++;
         complete_run();
      end
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      check_val({8'h00, carrier_word_q}, 32'h00e4_c000);
      check_val(osc_enable_q, 1'b1);
      rd8(`SFC_IDX_CTRL, 8'h01);
      rd8(`SFC_IDX_PIN_MAP_TWO, 8'h00);
      rd8(`SFC_IDX_BAT_THRESH, 8'h02);
      rd8(`SFC_IDX_IRQ_MASK, 8'h00);
      rd8(8'hf0, 8'h00);
      $display("test reset done");
      for (i = 0; i < 3000 && rx_enable_q !== 1'b1; i++) @(posedge clk_sys);
      check_val(pll_enable_q, 1'b1);
      check_val(rx_enable_q, 1'b1);
      check_val({saw_coarse, saw_fine}, 2'b11);
      check_val(general_pin_q[0], 1'b1);
      // The clock output runs from reset without any write, at half the reference.
      toggles(n);
      check_val(n, 64);
      $display("test startup done");
      seed = lfsr_next(lfsr_next(seed));
      bus(1'b1, `SFC_IDX_FREQ_HI, seed[23:16]);
      bus(1'b1, `SFC_IDX_FREQ_MID, seed[15:8]);
      check_val({8'h00, carrier_word_q}, 32'h00e4_c000);
      bus(1'b1, `SFC_IDX_FREQ_LO, seed[7:0]);
      check_val({8'h00, carrier_word_q}, {8'h00, seed[23:0]});
      repeat (2) @(posedge clk_sys);
      check_val(general_pin_q[0], 1'b0);
      for (i = 0; i < 300 && general_pin_q[0] !== 1'b1; i++) @(posedge clk_sys);
      check_val(general_pin_q[0], 1'b1);
      $display("test carrier done");
      // The pin copy of the select bit moves one edge after the register.
      for (k = 0; k < 2; k++) begin
         bus(1'b1, `SFC_IDX_REF_SEL, k ? 8'h00 : 8'h10);
         @(posedge clk_sys);
         check_val(ext_ref_sel_q, !k);
      end
      // Selects 0 and 1 both halve the reference; n from 2 to 6 divides by 2^n and 7 stops it.
      for (k = 0; k < 4; k++) begin
         bus(1'b1, `SFC_IDX_PIN_MAP_TWO, sel[k]);
         toggles(n);
         i = (sel[k] == 8'h07) ? 0 : (sel[k] == 8'h00) ? 64 : 64 >> (sel[k] - 8'h01);
         check_val(n >= i - 1 && n <= i + 1, 1'b1);
      end
      bus(1'b1, `SFC_IDX_PIN_MAP_TWO, 8'h00);
      bus(1'b1, `SFC_IDX_CTRL, 8'h11);
      repeat (20) @(posedge clk_sys);
      check_val(osc_enable_q, 1'b0);
      toggles(n);
      check_val(n, 0);
      bus(1'b1, `SFC_IDX_CTRL, 8'h01);
      for (i = 0; i < 3000 && rx_enable_q !== 1'b1; i++) @(posedge clk_sys);
      check_val({osc_enable_q, rx_enable_q}, 2'b11);
      $display("test clock output done");
      bus(1'b1, `SFC_IDX_IRQ_MASK, 8'h01);
      bus(1'b1, `SFC_IDX_PIN_MAP, 8'h02);
      supply_level <= 8'h01;
      for (i = 0; i < 50 && irq_q !== 1'b1; i++) @(posedge clk_sys);
      check_val({irq_q, general_pin_q[1]}, 2'b11);
      bus(1'b1, `SFC_IDX_IRQ_MASK, 8'h00);
      repeat (2) @(posedge clk_sys);
      check_val(irq_q, 1'b0);
      supply_level <= 8'h80;
      repeat (10) @(posedge clk_sys);
      bus(1'b1, `SFC_IDX_IRQ_STAT, 8'h01);
      bus(1'b1, `SFC_IDX_IRQ_MASK, 8'h01);
      repeat (2) @(posedge clk_sys);
      check_val(irq_q, 1'b0);
      $display("test interrupt done");
      complete_run();
   end
endmodule
`default_nettype wire
